/* dv/bud_counter_monitor.sv */
`timescale 1ns/1ps
// ----------------------------------------------------------------
// port checker of the up/down counter
// ----------------------------------------------------------------
module bud_counter_monitor #(
   parameter int CNT_W = 12
) (
   // clock, reset and bus
   input wire logic MCLK_I,
   input wire logic RST_N_I,
   input wire logic [bud_pkg::ADDR_W-1:0] AVS_ADDRESS_I,
   input wire logic AVS_READ_I,
   input wire logic AVS_WRITE_I,
   input wire logic AVS_WAITREQUEST_O,
   input wire logic [3:0] AVS_BYTEENABLE_I,
   input wire logic [bud_pkg::DATA_W-1:0] AVS_WRITEDATA_I,
   // counter pins and outputs
   input wire logic COUNT_IN_I,
   input wire logic ENABLE_I,
   input wire logic LOAD_N_I,
   input wire logic UP_DOWN_I,
   input wire logic [CNT_W-1:0] DATA_I,
   input wire logic [CNT_W-1:0] COUNT_O,
   input wire logic CARRY_O,
   input wire logic MAX_MIN_O
);
   logic cin_q;
   logic dir_q;
   logic [3:0] rise_age;
   logic [3:0] load_age;
   logic [3:0] swl_age;
   logic [3:0] en_low;
   logic [3:0] dir_same;

   // ages saturate so a long quiet stretch never wraps back to recent
   function automatic logic [3:0] age(input logic clr, input logic [3:0] a);
      age = clr ? 4'h0 : (a == 4'hF) ? a : a + 4'h1;
   endfunction

   // cycles since each possible cause of a count change, since enable was high and since the direction turned; reset counts as recent
   always_ff @(posedge MCLK_I) begin
      cin_q <= COUNT_IN_I;
      dir_q <= UP_DOWN_I;
      rise_age <= age(!RST_N_I || (COUNT_IN_I && !cin_q), rise_age);
      load_age <= age(!RST_N_I || !LOAD_N_I, load_age);
      swl_age <= age(!RST_N_I || (AVS_WRITE_I && !AVS_WAITREQUEST_O && AVS_ADDRESS_I[3:2] == 2'h2), swl_age);
      en_low <= age(!RST_N_I || ENABLE_I, en_low);
      dir_same <= age(!RST_N_I || (UP_DOWN_I != dir_q), dir_same);
   end

   logic src_q;
   logic [CNT_W-1:0] pre_q;
   logic wr_acc;

   // shadow of the load source and preset, so a held load knows what it must copy
   assign wr_acc = AVS_WRITE_I && !AVS_WAITREQUEST_O;
   always_ff @(posedge MCLK_I) begin
      if (!RST_N_I) begin
         src_q <= 1'b0;
         pre_q <= '0;
      end else if (wr_acc) begin
         if (AVS_ADDRESS_I[3:2] == 2'h2 && AVS_BYTEENABLE_I[0]) begin
            src_q <= AVS_WRITEDATA_I[bud_pkg::CTRL_SRC_BIT];
         end
         if (AVS_ADDRESS_I[3:2] == 2'h1 && AVS_BYTEENABLE_I[0]) begin
            pre_q[7:0] <= AVS_WRITEDATA_I[7:0];
         end
         if (AVS_ADDRESS_I[3:2] == 2'h1 && AVS_BYTEENABLE_I[1]) begin
            pre_q[CNT_W-1:8] <= AVS_WRITEDATA_I[CNT_W-1:8];
         end
      end
   end

   default clocking @(posedge MCLK_I); endclocking
   default disable iff (!RST_N_I);

   sequence s_one_wait;
      AVS_WAITREQUEST_O ##1 !AVS_WAITREQUEST_O;
   endsequence

   sequence s_load_held;
      (!LOAD_N_I && $stable(DATA_I)) [*5];
   endsequence

   AST_WAIT_ONE: assert property ($rose(AVS_READ_I || AVS_WRITE_I) |-> s_one_wait)
      else $error("bus answer not after exactly one wait cycle");
   AST_STEP_CAUSE: assert property (
      $changed(COUNT_O) |-> (rise_age inside {[1:3]}) || load_age <= 4'h3 || swl_age <= 4'h1)
      else $error("count changed without a rise, load or software load");
   AST_EN_HOLD: assert property (
      (en_low > 4'h4 && load_age > 4'h4 && swl_age > 4'h2) |-> $stable(COUNT_O))
      else $error("count moved while enable was low");
   // a held load copies the data pins, or the preset once software picked it as source
   AST_LOAD_COPY: assert property (s_load_held |-> COUNT_O == (src_q ? pre_q : DATA_I))
      else $error("held load did not copy the data pins");
   AST_STEP_UP: assert property (
      ($changed(COUNT_O) && load_age > 4'h4 && swl_age > 4'h2 && dir_same > 4'h5 && !UP_DOWN_I)
      |-> COUNT_O == $past(COUNT_O) + 1'h1)
      else $error("up step is not plus one");
   AST_STEP_DOWN: assert property (
      ($changed(COUNT_O) && load_age > 4'h4 && swl_age > 4'h2 && dir_same > 4'h5 && UP_DOWN_I)
      |-> COUNT_O == $past(COUNT_O) - 1'h1)
      else $error("down step is not minus one");
   AST_MAXMIN: assert property (
      ($stable(COUNT_O) && $stable(UP_DOWN_I)) [*6]
      |-> MAX_MIN_O == (UP_DOWN_I ? COUNT_O == bud_pkg::CNT_MIN : COUNT_O == bud_pkg::CNT_MAX))
      else $error("terminal flag wrong for count and direction");
   AST_CARRY: assert property (CARRY_O |-> $past(COUNT_IN_I, 3))
      else $error("carry high while the count input was low");
endmodule

/* dv/bud_pulse_model.sv */
`timescale 1ns/1ps
// ----------------------------------------------------------------
// count pulse source standing for the driving logic
// ----------------------------------------------------------------
module bud_pulse_model (
   // clock
   input wire logic clk_i,
   // driven pins
   output logic count_o,
   output logic dir_o
);
   // idle low and counting up until the first pulse
   initial begin
      count_o = 1'b0;
      dir_o = 1'b0;
   end

   // direction turns only while high, well clear of the fall
   task automatic pulse(input logic down);
      @(posedge clk_i);
      count_o <= 1'b1;
      repeat (2) @(posedge clk_i);
      dir_o <= down;
      repeat (12) @(posedge clk_i);
      count_o <= 1'b0;
      repeat (22) @(posedge clk_i);
   endtask
endmodule

/* dv/tb_binary_up_down_counter_12b.sv */
`timescale 1ns/1ps
module tb_binary_up_down_counter_12b;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [3:0] adr = 4'h0;
   logic rd = 1'b0;
   logic wr = 1'b0;
   logic [31:0] wdat = 32'h0;
   logic [31:0] rdat;
   logic waitreq;
   logic cin;
   logic en = 1'b1;
   logic ld_n = 1'b1;
   logic dir;
   logic [11:0] data = 12'h000;
   logic [11:0] cnt;
   logic carry;
   logic mm;
   logic m_dir = 1'b0;
   logic [11:0] p;
   logic [31:0] q;
   integer error_cnt = 0;
   integer n_checks = 0;
   integer seed = 63010;
   integer cyc = 0;
   integer carry_cyc = 0;
   integer m_cnt = 0;
   integer m_steps = 0;

   always #2 clk = ~clk;

   // carry cycles per pulse, and the hang limit
   always @(posedge clk) begin
      cyc = cyc + 1;
      if (carry === 1'b1) carry_cyc = carry_cyc + 1;
      if (cyc == 10000) begin
         error_cnt = error_cnt + 1;
         end_of_test();
      end
   end

   bud_counter bud_counter_inst (.MCLK_I(clk), .RST_N_I(rst_n), .AVS_ADDRESS_I(adr), .AVS_READ_I(rd),
      .AVS_WRITE_I(wr), .AVS_BYTEENABLE_I(4'hF), .AVS_WRITEDATA_I(wdat), .AVS_READDATA_O(rdat),
      .AVS_WAITREQUEST_O(waitreq), .COUNT_IN_I(cin), .ENABLE_I(en), .LOAD_N_I(ld_n), .UP_DOWN_I(dir),
      .DATA_I(data), .COUNT_O(cnt), .CARRY_O(carry), .MAX_MIN_O(mm));
   bud_pulse_model bud_pulse_model_inst (.clk_i(clk), .count_o(cin), .dir_o(dir));

   task chk(input logic [31:0] seen, input logic [31:0] exp);
      n_checks = n_checks + 1;
      if (seen !== exp) begin
         error_cnt = error_cnt + 1;
         $display("ERROR %0t: got %h expected %h", $time, seen, exp);
      end
   endtask

   task end_of_test;
      if (error_cnt == 0 && n_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask

   // one bus access, held until waitrequest is seen low
   task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
      integer t;
      t = 0;
      @(posedge clk);
      adr <= a;
      wr <= w;
      rd <= !w;
      wdat <= d;
      do begin
         @(posedge clk);
         t = t + 1;
      end while (waitreq !== 1'b0);
      q = rdat;
      rd <= 1'b0;
      wr <= 1'b0;
      chk(t, 2);
   endtask

   // model: a carry lasts the whole high time at a boundary, one cycle if it wraps,
   // and the rest of the high time after a step that lands on the boundary
   task pulse(input logic down);
      integer ec;
      logic bnd;
      logic st;
      bnd = m_dir ? (m_cnt == 0) : (m_cnt == 4095);
      st = en && ld_n;
      ec = (down != m_dir) ? -1 : (!ld_n || !bnd) ? 0 : st ? 1 : 14;
      carry_cyc = 0;
      bud_pulse_model_inst.pulse(down);
      if (st) begin
         m_cnt = m_dir ? (m_cnt + 4095) % 4096 : (m_cnt + 1) % 4096;
         m_steps = m_steps + 1;
         if (ec == 0 && (m_dir ? m_cnt == 0 : m_cnt == 4095)) ec = 13;
      end
      m_dir = down;
      chk(cnt, m_cnt);
      chk(mm, m_dir ? m_cnt == 0 : m_cnt == 4095);
      if (ec >= 0) chk(carry_cyc, ec);
   endtask

   // load held long, with a pulse thrown in that must be ignored
   task load(input logic [11:0] v);
      @(posedge clk);
      ld_n <= 1'b0;
      data <= v;
      repeat (14) @(posedge clk);
      m_cnt = v;
      chk(cnt, v);
      pulse(m_dir);
      ld_n <= 1'b1;
      repeat (4) @(posedge clk);
   endtask

   task set_en(input logic e);
      en <= e;
      repeat (18) @(posedge clk);
   endtask

   initial begin
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      repeat (20) @(posedge clk);
      chk(cnt, 0);
      chk(mm, 0);
      repeat (5) pulse(1'b0);
      load(12'hFFE);
      repeat (2) pulse(1'b0);
      load(12'hFFF);
      set_en(1'b0);
      pulse(1'b0);
      pulse(1'b1);
      set_en(1'b1);
      // divide by two: load two and count it down to zero, twice over
      repeat (2) begin
         load(12'h002);
         repeat (2) pulse(1'b1);
      end
      pulse(1'b1);
      repeat (16) begin
         set_en(1'($random(seed)));
         pulse(1'($random(seed)));
      end
      // software load through the preset, then the read side of each register
      p = 12'($random(seed));
      bus(1'b1, bud_pkg::OFF_PRESET, {20'h0, p});
      bus(1'b1, bud_pkg::OFF_CTRL, 32'h0000_0005);
      m_cnt = p;
      @(posedge clk);
      chk(cnt, p);
      bus(1'b1, bud_pkg::OFF_COUNT, 32'h0000_0FFF);
      @(posedge clk);
      chk(cnt, p);
      bus(1'b0, bud_pkg::OFF_PRESET, 32'h0);
      chk(q, {20'h0, p});
      bus(1'b0, bud_pkg::OFF_CTRL, 32'h0);
      chk(q, 32'h0000_0004);
      bus(1'b0, bud_pkg::OFF_COUNT, 32'h0);
      chk(q, {16'h0, 1'b0, en, m_dir, m_dir ? p == 12'h000 : p == 12'hFFF, p});
      bus(1'b0, bud_pkg::OFF_STEPS, 32'h0);
      chk(q, m_steps);
      bus(1'b1, bud_pkg::OFF_STEPS, 32'h0);
      bus(1'b0, bud_pkg::OFF_STEPS, 32'h0);
      chk(q, 0);
      // pin load with the preset picked as the source; the data pins must lose
      bus(1'b1, bud_pkg::OFF_CTRL, 32'h0000_0006);
      ld_n <= 1'b0;
      data <= ~p;
      repeat (14) @(posedge clk);
      chk(cnt, p);
      ld_n <= 1'b1;
      bus(1'b1, bud_pkg::OFF_CTRL, 32'h0000_0004);
      end_of_test();
   end
endmodule

bind bud_counter bud_counter_monitor #(.CNT_W(CNT_W)) bud_counter_monitor_inst (
   .MCLK_I(MCLK_I), .RST_N_I(RST_N_I), .AVS_ADDRESS_I(AVS_ADDRESS_I), .AVS_READ_I(AVS_READ_I),
   .AVS_WRITE_I(AVS_WRITE_I), .AVS_WAITREQUEST_O(AVS_WAITREQUEST_O), .AVS_BYTEENABLE_I(AVS_BYTEENABLE_I),
   .AVS_WRITEDATA_I(AVS_WRITEDATA_I), .COUNT_IN_I(COUNT_IN_I),
   .ENABLE_I(ENABLE_I), .LOAD_N_I(LOAD_N_I), .UP_DOWN_I(UP_DOWN_I), .DATA_I(DATA_I),
   .COUNT_O(COUNT_O), .CARRY_O(CARRY_O), .MAX_MIN_O(MAX_MIN_O));

/* hdl/bud_counter.sv */
`timescale 1ns/1ps
module bud_counter #(
   parameter int CNT_W = bud_pkg::CNT_W,
   parameter int STEPS_W = bud_pkg::STEPS_W
) (
   // clock and reset
   input wire logic MCLK_I,
   input wire logic RST_N_I,
   // avalon-mm slave
   input wire logic [bud_pkg::ADDR_W-1:0] AVS_ADDRESS_I,
   input wire logic AVS_READ_I,
   input wire logic AVS_WRITE_I,
   input wire logic [3:0] AVS_BYTEENABLE_I,
   input wire logic [bud_pkg::DATA_W-1:0] AVS_WRITEDATA_I,
   output logic [bud_pkg::DATA_W-1:0] AVS_READDATA_O,
   output logic AVS_WAITREQUEST_O,
   // counter pins
   input wire logic COUNT_IN_I,
   input wire logic ENABLE_I,
   input wire logic LOAD_N_I,
   input wire logic UP_DOWN_I,
   input wire logic [CNT_W-1:0] DATA_I,
   // counter outputs
   output logic [CNT_W-1:0] COUNT_O,
   output logic CARRY_O,
   output logic MAX_MIN_O
);

   // ----------------------------------------------------------------
   // pin synchronisation
   // ----------------------------------------------------------------
   bud_pkg::bud_pins_s pins_raw;
   bud_pkg::bud_pins_s pins;
   logic [15:0] pins_sync;

   // all pins arrive from outside the clock domain
   always_comb begin
      pins_raw.count_in = COUNT_IN_I;
      pins_raw.enable = ENABLE_I;
      pins_raw.load_n = LOAD_N_I;
      pins_raw.dir_down = UP_DOWN_I;
      pins_raw.data = DATA_I;
   end

   bud_sync #(
      .W(16),
      .RST_VAL(bud_pkg::RST_PINS)
   ) u_sync (
      .clk_i(MCLK_I),
      .rst_n_i(RST_N_I),
      .async_i(pins_raw),
      .sync_o(pins_sync)
   );

   assign pins = pins_sync;

   // ----------------------------------------------------------------
   // register state
   // ----------------------------------------------------------------
   logic [CNT_W-1:0] count_reg;
   logic [CNT_W-1:0] count_next;
   logic term_reg;
   logic term_next;
   logic carry_reg;
   logic carry_next;
   logic lvl_prev_reg;
   logic lvl_prev_next;
   logic [bud_pkg::LOWCNT_W-1:0] low_cnt_reg;
   logic [bud_pkg::LOWCNT_W-1:0] low_cnt_next;
   logic [STEPS_W-1:0] steps_reg;
   logic [STEPS_W-1:0] steps_next;
   logic [CNT_W-1:0] preset_reg;
   logic [CNT_W-1:0] preset_next;
   bud_pkg::bud_ctrl_s ctrl_reg;
   bud_pkg::bud_ctrl_s ctrl_next;
   logic ack_reg;
   logic ack_next;
   logic [bud_pkg::DATA_W-1:0] rdata_reg;
   logic [bud_pkg::DATA_W-1:0] rdata_next;

   // ----------------------------------------------------------------
   // bus decode
   // ----------------------------------------------------------------
   logic req;
   logic wr_go;
   logic rd_cap;
   logic [bud_pkg::ADDR_W-1:0] addr_w;
   logic sw_load;
   logic steps_clr;

   // one wait cycle: request seen, answered at the following edge
   assign req = AVS_READ_I | AVS_WRITE_I;
   assign wr_go = AVS_WRITE_I & ack_reg;
   assign rd_cap = AVS_READ_I & ~ack_reg;
   assign addr_w = {AVS_ADDRESS_I[bud_pkg::ADDR_W-1:2], 2'h0};

   // software load is a write of one to the load bit of the control word
   assign sw_load = wr_go && (addr_w == bud_pkg::OFF_CTRL) && AVS_BYTEENABLE_I[0]
      && AVS_WRITEDATA_I[bud_pkg::CTRL_LOAD_BIT];
   assign steps_clr = wr_go && (addr_w == bud_pkg::OFF_STEPS) && (AVS_BYTEENABLE_I != 4'h0);

   // ----------------------------------------------------------------
   // count edge qualification
   // ----------------------------------------------------------------
   logic low_ok;
   logic cnt_edge;
   logic step;
   logic load_act;
   logic [CNT_W-1:0] load_val;

   // a rise is a count only after the input sat low long enough; short
   // lows are treated as noise since the driver keeps the minimum low time
   assign low_ok = (low_cnt_reg >= bud_pkg::LOWCNT_W'(bud_pkg::CNT_LOW_MIN_CYC));
   assign cnt_edge = pins.count_in & ~lvl_prev_reg & low_ok;
   // a rise that meets a load is neither applied nor counted as a step
   assign step = cnt_edge & pins.enable & ctrl_reg.gate_en & ~load_act;

   // pin load copies the data pins, or the preset word when selected
   assign load_act = ~pins.load_n | sw_load;
   assign load_val = (sw_load | ctrl_reg.preset_src) ? preset_reg : pins.data;

   // edge tracking; the low counter saturates so it never wraps
   always_comb begin
      lvl_prev_next = pins.count_in;
      low_cnt_next = low_cnt_reg;
      if (pins.count_in) begin
         low_cnt_next = '0;
      end else if (!low_ok) begin
         low_cnt_next = low_cnt_reg + 1'b1;
      end
   end

   always_ff @(posedge MCLK_I) begin
      if (!RST_N_I) begin
         lvl_prev_reg <= 1'b0;
         low_cnt_reg <= '0;
      end else begin
         lvl_prev_reg <= lvl_prev_next;
         low_cnt_reg <= low_cnt_next;
      end
   end

   // ----------------------------------------------------------------
   // count core
   // ----------------------------------------------------------------
   // load is checked first, so it overrides any step in the same cycle;
   // direction only picks the step sign and never touches the value
   always_comb begin
      count_next = count_reg;
      if (load_act) begin
         count_next = load_val;
      end else if (step) begin
         if (pins.dir_down) begin
            count_next = count_reg - 1'b1;
         end else begin
            count_next = count_reg + 1'b1;
         end
      end
   end

   // flag tracks the new count against the present direction, so a
   // direction change alone moves the flag but not the count
   always_comb begin
      term_next = bud_pkg::bud_is_term(count_next, pins.dir_down);
   end

   // carry follows the input level while at the boundary; the old count is
   // used so the wrapping edge itself passes through to the next stage
   always_comb begin
      carry_next = pins.count_in & ~load_act
         & bud_pkg::bud_is_term(count_reg, pins.dir_down);
   end

   // accepted step count for software, clear with a step in the same cycle leaves one
   always_comb begin
      steps_next = steps_reg;
      if (steps_clr) begin
         steps_next = step ? STEPS_W'(1) : '0;
      end else if (step) begin
         steps_next = steps_reg + 1'b1;
      end
   end

   always_ff @(posedge MCLK_I) begin
      if (!RST_N_I) begin
         count_reg <= bud_pkg::RST_COUNT;
         term_reg <= 1'b0;
         carry_reg <= 1'b0;
         steps_reg <= bud_pkg::RST_STEPS;
      end else begin
         count_reg <= count_next;
         term_reg <= term_next;
         carry_reg <= carry_next;
         steps_reg <= steps_next;
      end
   end

   // ----------------------------------------------------------------
   // software registers
   // ----------------------------------------------------------------
   // preset and control honour byte enables; count is read only
   always_comb begin
      preset_next = preset_reg;
      ctrl_next = ctrl_reg;
      if (wr_go && addr_w == bud_pkg::OFF_PRESET) begin
         if (AVS_BYTEENABLE_I[0]) begin
            preset_next[7:0] = AVS_WRITEDATA_I[7:0];
         end
         if (AVS_BYTEENABLE_I[1]) begin
            preset_next[CNT_W-1:8] = AVS_WRITEDATA_I[CNT_W-1:8];
         end
      end
      if (wr_go && addr_w == bud_pkg::OFF_CTRL && AVS_BYTEENABLE_I[0]) begin
         ctrl_next.preset_src = AVS_WRITEDATA_I[bud_pkg::CTRL_SRC_BIT];
         ctrl_next.gate_en = AVS_WRITEDATA_I[bud_pkg::CTRL_GATE_BIT];
      end
   end

   always_ff @(posedge MCLK_I) begin
      if (!RST_N_I) begin
         preset_reg <= bud_pkg::RST_PRESET;
         ctrl_reg <= bud_pkg::RST_CTRL;
      end else begin
         preset_reg <= preset_next;
         ctrl_reg <= ctrl_next;
      end
   end

   // ----------------------------------------------------------------
   // bus handshake and read data
   // ----------------------------------------------------------------
   // read data is captured in the wait cycle and stands at the answer edge;
   // unmapped offsets read as zero and ignore writes
   always_comb begin
      ack_next = req & ~ack_reg;
      rdata_next = rdata_reg;
      if (rd_cap) begin
         rdata_next = '0;
         unique case (addr_w)
            bud_pkg::OFF_COUNT: begin
               rdata_next[CNT_W-1:0] = count_reg;
               rdata_next[bud_pkg::COUNT_TERM_BIT] = term_reg;
               rdata_next[bud_pkg::COUNT_DIR_BIT] = pins.dir_down;
               rdata_next[bud_pkg::COUNT_EN_BIT] = pins.enable;
               rdata_next[bud_pkg::COUNT_LOAD_BIT] = ~pins.load_n;
            end
            bud_pkg::OFF_PRESET: begin
               rdata_next[CNT_W-1:0] = preset_reg;
            end
            bud_pkg::OFF_CTRL: begin
               rdata_next[bud_pkg::CTRL_SRC_BIT] = ctrl_reg.preset_src;
               rdata_next[bud_pkg::CTRL_GATE_BIT] = ctrl_reg.gate_en;
            end
            bud_pkg::OFF_STEPS: begin
               rdata_next[STEPS_W-1:0] = steps_reg;
            end
            default: begin
               rdata_next = '0;
            end
         endcase
      end
   end

   always_ff @(posedge MCLK_I) begin
      if (!RST_N_I) begin
         ack_reg <= 1'b0;
         rdata_reg <= '0;
      end else begin
         ack_reg <= ack_next;
         rdata_reg <= rdata_next;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   // waitrequest is combinational so an idle bus sees it low
   assign AVS_WAITREQUEST_O = req & ~ack_reg;
   assign AVS_READDATA_O = rdata_reg;
   assign COUNT_O = count_reg;
   assign CARRY_O = carry_reg;
   assign MAX_MIN_O = term_reg;

endmodule

/* hdl/bud_sync.sv */
`timescale 1ns/1ps
// ----------------------------------------------------------------
// two-flop synchroniser for pin levels
// ----------------------------------------------------------------
module bud_sync #(
   parameter int W = 16,
   parameter logic [W-1:0] RST_VAL = '0
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // levels
   input wire logic [W-1:0] async_i,
   output logic [W-1:0] sync_o
);

   logic [W-1:0] meta_reg;
   logic [W-1:0] meta_next;
   logic [W-1:0] sync_reg;
   logic [W-1:0] sync_next;

   // first stage feeds only the second stage
   always_comb begin
      meta_next = async_i;
      sync_next = meta_reg;
   end

   // reset value chosen so no load or edge is seen on release
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         meta_reg <= RST_VAL;
         sync_reg <= RST_VAL;
      end else begin
         meta_reg <= meta_next;
         sync_reg <= sync_next;
      end
   end

   assign sync_o = sync_reg;

endmodule

/* shared/bud_pkg.sv */
// ----------------------------------------------------------------
// shared definitions of the 12-bit up/down counter
// ----------------------------------------------------------------
package bud_pkg;

   // ----------------------------------------------------------------
   // widths
   // ----------------------------------------------------------------
   localparam int CNT_W = 12;
   localparam int ADDR_W = 4;
   localparam int DATA_W = 32;
   localparam int STEPS_W = 16;
   localparam int LOWCNT_W = 8;

   // ----------------------------------------------------------------
   // register offsets (byte addresses)
   // ----------------------------------------------------------------
   localparam logic [ADDR_W-1:0] OFF_COUNT = 4'h0;
   localparam logic [ADDR_W-1:0] OFF_PRESET = 4'h4;
   localparam logic [ADDR_W-1:0] OFF_CTRL = 4'h8;
   localparam logic [ADDR_W-1:0] OFF_STEPS = 4'hC;

   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int COUNT_TERM_BIT = 12;
   localparam int COUNT_DIR_BIT = 13;
   localparam int COUNT_EN_BIT = 14;
   localparam int COUNT_LOAD_BIT = 15;
   localparam int CTRL_LOAD_BIT = 0;
   localparam int CTRL_SRC_BIT = 1;
   localparam int CTRL_GATE_BIT = 2;

   // ----------------------------------------------------------------
   // reset values and boundaries
   // ----------------------------------------------------------------
   localparam logic [CNT_W-1:0] RST_COUNT = 12'h000;
   localparam logic [CNT_W-1:0] RST_PRESET = 12'h000;
   localparam logic [STEPS_W-1:0] RST_STEPS = 16'h0000;
   localparam logic [CNT_W-1:0] CNT_MAX = 12'hFFF;
   localparam logic [CNT_W-1:0] CNT_MIN = 12'h000;
   localparam logic [15:0] RST_PINS = 16'h2000;

   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_PS = 4000;
   localparam int CNT_LOW_MIN_NS = 50;
   localparam int LOAD_MIN_NS = 50;
   localparam int CNT_LOW_MIN_CYC = (CNT_LOW_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int LOAD_MIN_CYC = (LOAD_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

   // ----------------------------------------------------------------
   // carriers
   // ----------------------------------------------------------------
   typedef struct packed {
      logic count_in;
      logic enable;
      logic load_n;
      logic dir_down;
      logic [CNT_W-1:0] data;
   } bud_pins_s;

   typedef struct packed {
      logic gate_en;
      logic preset_src;
   } bud_ctrl_s;

   localparam bud_ctrl_s RST_CTRL = '{gate_en: 1'b1, preset_src: 1'b0};

   // boundary for the current direction: all ones up, all zeros down
   function automatic logic bud_is_term(input logic [CNT_W-1:0] cnt, input logic dir_down);
      bud_is_term = dir_down ? (cnt == CNT_MIN) : (cnt == CNT_MAX);
   endfunction

endpackage
